// >>> src/old_params.svh
// Constants for the output logic and delay block: offsets, fields, resets, timing
`ifndef OLD_PARAMS_SVH
`define OLD_PARAMS_SVH

// Register byte offsets
`define OLD_OFS_COMB_CFG 8'h00
`define OLD_OFS_ROUTE_CFG 8'h04
`define OLD_OFS_TERM_ONE_DLY 8'h08
`define OLD_OFS_TERM_TWO_DLY 8'h0C
`define OLD_OFS_RELAY_DLY 8'h10
`define OLD_OFS_STATUS 8'h14

// Combiner configuration fields
`define OLD_CFG_A_LSB 0
`define OLD_CFG_B_LSB 4
`define OLD_CFG_OP_LSB 8
`define OLD_CFG_RESP_LSB 12

// Routing fields, one 4-bit source code per output
`define OLD_ROUTE_W 4

// Delay register fields
`define OLD_DLY_ON_LSB 0
`define OLD_DLY_OFF_LSB 16
`define OLD_DLY_W 10

// Status fields
`define OLD_ST_OUT_LSB 0
`define OLD_ST_TRIP_BIT 3
`define OLD_ST_COMB_BIT 4
`define OLD_ST_MOTOR_BIT 5
`define OLD_ST_FUNC_LSB 8

// Reset values
`define OLD_RST_A_SEL 4'h0
`define OLD_RST_B_SEL 4'h1
`define OLD_RST_OP 2'h0
`define OLD_RST_RESP 2'h0
`define OLD_RST_ROUTE_ONE 4'h0
`define OLD_RST_ROUTE_TWO 4'h1
`define OLD_RST_ROUTE_RELAY 4'h9
`define OLD_RST_DLY 10'h000

// Source codes and limits
`define OLD_FUNC_COUNT 9
`define OLD_SRC_COMBINED 4'h9
`define OLD_DLY_MAX 10'd1000

// Timing: step and forced hold in ms, clock in MHz
`define OLD_CLK_MHZ 250
`define OLD_STEP_MS 100
`define OLD_FORCE_HOLD_MS 1000
`define OLD_STEP_CYCLES (`OLD_STEP_MS * `OLD_CLK_MHZ * 1000)
`define OLD_FORCE_HOLD_STEPS (`OLD_FORCE_HOLD_MS / `OLD_STEP_MS)

`endif

// >>> src/old_pkg.sv
// Types shared by the output logic and delay block
package old_pkg;

    // Combiner operator codes
    typedef enum logic [1:0] {
        OLD_OP_AND,
        OLD_OP_OR,
        OLD_OP_XOR,
        OLD_OP_NONE
    } old_op_t;

    // Fault clear response codes
    typedef enum logic [1:0] {
        OLD_RESP_RISE_STOP,
        OLD_RESP_FALL_STOP,
        OLD_RESP_RISE_IDLE,
        OLD_RESP_NONE
    } old_resp_t;

    // Delay timer states
    typedef enum logic {
        OLD_TMR_IDLE,
        OLD_TMR_WAIT
    } old_tmr_state_t;

endpackage : old_pkg

// >>> src/old_sync2.sv
// Two flip-flop synchroniser for one level from outside the clock domain
`timescale 1ns/10ps
module old_sync2 (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta;

    // First stage feeds only the second stage
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            meta <= 1'b0;
            o_sync <= 1'b0;
        end
        else
        begin
            meta <= i_async;
            o_sync <= meta;
        end
    end
endmodule : old_sync2

// >>> src/old_delay_timer.sv
// Transition delay timer for one physical output
`timescale 1ns/10ps
`include "old_params.svh"
module old_delay_timer #(
    parameter int TICK_CYCLES = `OLD_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_level,
    input wire logic i_force_off,
    input wire logic [`OLD_DLY_W-1:0] i_on_delay,
    input wire logic [`OLD_DLY_W-1:0] i_off_delay,
    output logic o_level
);
    import old_pkg::*;

    localparam int PW = $clog2(TICK_CYCLES + 1);
    localparam logic [PW-1:0] PRE_LAST = PW'(TICK_CYCLES - 1);
    localparam logic [`OLD_DLY_W-1:0] HOLD_STEPS = `OLD_DLY_W'(`OLD_FORCE_HOLD_STEPS);

    old_tmr_state_t state;
    old_tmr_state_t next_state;
    logic [PW-1:0] pre;
    logic [PW-1:0] next_pre;
    logic [`OLD_DLY_W-1:0] steps;
    logic [`OLD_DLY_W-1:0] next_steps;
    logic next_level;

    // Forced off wins over the undelayed level
    wire target = i_level & ~i_force_off;
    wire differs = target != o_level;
    wire off_used = i_off_delay != '0;
    // Forced off keeps an output that uses an off delay on for about one second
    wire [`OLD_DLY_W-1:0] off_need = i_force_off ? (off_used ? HOLD_STEPS : '0) : i_off_delay;
    wire [`OLD_DLY_W-1:0] need = target ? i_on_delay : off_need;
    wire [`OLD_DLY_W-1:0] steps_inc = steps + `OLD_DLY_W'(1);

    // Step counting; comparing with >= lets a shortened need end the wait at the end of the current step
    always_comb
    begin
        next_state = state;
        next_pre = pre;
        next_steps = steps;
        next_level = o_level;
        if (!differs)
        begin
            next_state = OLD_TMR_IDLE;
            next_pre = '0;
            next_steps = '0;
        end
        else if (need == '0)
        begin
            next_level = target;
            next_state = OLD_TMR_IDLE;
        end
        else
        begin
            case (state)
                OLD_TMR_IDLE:
                begin
                    next_state = OLD_TMR_WAIT;
                    next_pre = '0;
                    next_steps = '0;
                end
                OLD_TMR_WAIT:
                begin
                    if (pre == PRE_LAST)
                    begin
                        next_pre = '0;
                        next_steps = steps_inc;
                        if (steps_inc >= need)
                        begin
                            next_level = target;
                            next_state = OLD_TMR_IDLE;
                            next_steps = '0;
                        end
                    end
                    else
                    begin
                        next_pre = pre + PW'(1);
                    end
                end
                default:
                begin
                    next_state = OLD_TMR_IDLE;
                end
            endcase
        end
    end

    // Timer state
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            state <= OLD_TMR_IDLE;
            pre <= '0;
            steps <= '0;
            o_level <= 1'b0;
        end
        else
        begin
            state <= next_state;
            pre <= next_pre;
            steps <= next_steps;
            o_level <= next_level;
        end
    end
endmodule : old_delay_timer

// >>> src/old_output_logic.sv
// Output combiner, routing, transition delays and fault clear handling with APB registers
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/10ps
`include "old_params.svh"

// Operation
// - The combiner applies AND for code 0, OR for code 1 and XOR for code 2 to inputs A and B.
// - Inputs A and B each pick one of nine status functions, A defaulting to 0 and B to 1.
// - The combined output follows the plain truth tables of AND, OR and XOR.
// - The combined result can be routed to terminal one, terminal two or the relay.
// - Every output delays its rising edge, falling edge or both by its own two settings.
// - Delays count in steps of 0.1 s and reach at most 100.0 s.
// - Six delay settings exist, an on and an off delay per output, all reset to zero.
// - Without off delays the fault clear input turns the motor and all outputs off at once, except under code 2 while running.
// - An output with a nonzero off delay stays on about 1 s more after fault clear rises.
// - Response code 0 clears the trip on the rising edge and stops a running drive.
// - Response code 1 clears the trip on the falling edge and stops a running drive.
// - Response code 2 clears the trip on the rising edge and is ignored while running.
module old_output_logic #(
    parameter int TICK_CYCLES = `OLD_STEP_CYCLES
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [7:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    input wire logic [`OLD_FUNC_COUNT-1:0] i_status_func,
    input wire logic i_trip_event,
    input wire logic i_running,
    input wire logic i_run_command,
    input wire logic i_fault_clear_input,
    output logic o_term_one,
    output logic o_term_two,
    output logic o_relay,
    output logic o_motor_enable,
    output logic o_trip_state,
    output logic o_stop_request
);
    import old_pkg::*;

    localparam int NOUT = 3;

    // Configuration registers
    logic [3:0] combiner_input_a_select;
    logic [3:0] combiner_input_b_select;
    logic [1:0] combiner_operator_select;
    logic [1:0] fault_clear_response_select;
    logic [`OLD_ROUTE_W-1:0] route [NOUT];
    logic [`OLD_DLY_W-1:0] on_delay [NOUT];
    logic [`OLD_DLY_W-1:0] off_delay [NOUT];

    // Bus answer and control state
    logic [31:0] rd_hold;
    logic err_hold;
    logic clear_level;
    logic clear_prev;
    logic [NOUT-1:0] out_level;

    // APB phase decode; zero wait states, read data caught in the setup cycle
    wire setup = i_psel & ~i_penable;
    wire access = i_psel & i_penable;
    wire wr_en = access & i_pwrite;
    wire hit_cfg = i_paddr == `OLD_OFS_COMB_CFG;
    wire hit_route = i_paddr == `OLD_OFS_ROUTE_CFG;
    wire hit_status = i_paddr == `OLD_OFS_STATUS;
    wire [NOUT-1:0] hit_dly;
    assign hit_dly[0] = i_paddr == `OLD_OFS_TERM_ONE_DLY;
    assign hit_dly[1] = i_paddr == `OLD_OFS_TERM_TWO_DLY;
    assign hit_dly[2] = i_paddr == `OLD_OFS_RELAY_DLY;
    wire mapped = hit_cfg | hit_route | hit_status | (|hit_dly);

    // Written delays saturate at the longest allowed setting
    wire [`OLD_DLY_W-1:0] wr_on_raw = i_pwdata[`OLD_DLY_ON_LSB +: `OLD_DLY_W];
    wire [`OLD_DLY_W-1:0] wr_off_raw = i_pwdata[`OLD_DLY_OFF_LSB +: `OLD_DLY_W];
    wire [`OLD_DLY_W-1:0] wr_on = (wr_on_raw > `OLD_DLY_MAX) ? `OLD_DLY_MAX : wr_on_raw;
    wire [`OLD_DLY_W-1:0] wr_off = (wr_off_raw > `OLD_DLY_MAX) ? `OLD_DLY_MAX : wr_off_raw;

    // Combiner input selection; codes past the last function read as zero
    wire [15:0] func_ext = {7'h00, i_status_func};
    wire in_a = func_ext[combiner_input_a_select];
    wire in_b = func_ext[combiner_input_b_select];
    wire op_and = in_a & in_b;
    wire op_or = in_a | in_b;
    wire op_xor = in_a ^ in_b;
    wire [1:0] op_code = combiner_operator_select;
    wire combined = (op_code == OLD_OP_AND) ? op_and :
                    (op_code == OLD_OP_OR) ? op_or :
                    (op_code == OLD_OP_XOR) ? op_xor : 1'b0;

    // Route sources: function codes, combined result at code 9
    wire [15:0] src_vec = {6'h00, combined, i_status_func};

    // Fault clear edges on the synchronised level
    wire clear_rise = clear_level & ~clear_prev;
    wire clear_fall = ~clear_level & clear_prev;
    wire [1:0] resp = fault_clear_response_select;
    wire resp_rise_stop = resp == OLD_RESP_RISE_STOP;
    wire resp_fall_stop = resp == OLD_RESP_FALL_STOP;
    wire resp_rise_idle = resp == OLD_RESP_RISE_IDLE;
    wire clear_evt = (resp_rise_stop & clear_rise)
                   | (resp_fall_stop & clear_fall)
                   | (resp_rise_idle & clear_rise & ~i_running);
    wire stop_evt = i_running & ((resp_rise_stop & clear_rise) | (resp_fall_stop & clear_fall));
    // Code 2 leaves a running drive and its outputs alone
    wire force_off = clear_level & ~(resp_rise_idle & i_running);
    // A trip event in the clearing cycle keeps the trip
    wire next_trip = i_trip_event | (o_trip_state & ~clear_evt);
    wire next_motor = i_run_command & ~o_trip_state & ~force_off;

    // Readback words
    wire [31:0] cfg_word = {18'h0, fault_clear_response_select, 2'h0,
                            combiner_operator_select, combiner_input_b_select,
                            combiner_input_a_select};
    wire [31:0] route_word = {20'h0, route[2], route[1], route[0]};
    wire [31:0] status_word = {15'h0, i_status_func, 2'h0, o_motor_enable, combined,
                               o_trip_state, out_level};
    wire [31:0] dly_word [NOUT];
    wire [31:0] dly_read;
    assign dly_read = hit_dly[0] ? dly_word[0] :
                      hit_dly[1] ? dly_word[1] :
                      hit_dly[2] ? dly_word[2] : 32'h0000_0000;
    wire [31:0] rd_data = hit_cfg ? cfg_word :
                          hit_route ? route_word :
                          hit_status ? status_word : dly_read;

    // One timer per output, fed from its routed source
    genvar k;
    generate
        for (k = 0; k < NOUT; k++)
        begin : g_out
            wire undelayed = src_vec[route[k]];
            assign dly_word[k] = {6'h00, off_delay[k], 6'h00, on_delay[k]};
            old_delay_timer #(
                .TICK_CYCLES(TICK_CYCLES)
            ) u_timer (
                .i_clk(i_clk),
                .i_reset_n(i_reset_n),
                .i_level(undelayed),
                .i_force_off(force_off),
                .i_on_delay(on_delay[k]),
                .i_off_delay(off_delay[k]),
                .o_level(out_level[k])
            );

            // Delay settings per output, zero after reset
            always_ff @(posedge i_clk or negedge i_reset_n)
            begin
                if (!i_reset_n)
                begin
                    on_delay[k] <= `OLD_RST_DLY;
                    off_delay[k] <= `OLD_RST_DLY;
                end
                else if (wr_en & hit_dly[k])
                begin
                    on_delay[k] <= wr_on;
                    off_delay[k] <= wr_off;
                end
            end
        end
    endgenerate

    // Synchronised fault clear pin
    old_sync2 u_clear_sync (
        .i_clk(i_clk),
        .i_reset_n(i_reset_n),
        .i_async(i_fault_clear_input),
        .o_sync(clear_level)
    );

    // Combiner configuration register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            combiner_input_a_select <= `OLD_RST_A_SEL;
            combiner_input_b_select <= `OLD_RST_B_SEL;
            combiner_operator_select <= `OLD_RST_OP;
            fault_clear_response_select <= `OLD_RST_RESP;
        end
        else if (wr_en & hit_cfg)
        begin
            combiner_input_a_select <= i_pwdata[`OLD_CFG_A_LSB +: 4];
            combiner_input_b_select <= i_pwdata[`OLD_CFG_B_LSB +: 4];
            combiner_operator_select <= i_pwdata[`OLD_CFG_OP_LSB +: 2];
            fault_clear_response_select <= i_pwdata[`OLD_CFG_RESP_LSB +: 2];
        end
    end

    // Routing register
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            route[0] <= `OLD_RST_ROUTE_ONE;
            route[1] <= `OLD_RST_ROUTE_TWO;
            route[2] <= `OLD_RST_ROUTE_RELAY;
        end
        else if (wr_en & hit_route)
        begin
            route[0] <= i_pwdata[0 +: `OLD_ROUTE_W];
            route[1] <= i_pwdata[`OLD_ROUTE_W +: `OLD_ROUTE_W];
            route[2] <= i_pwdata[2*`OLD_ROUTE_W +: `OLD_ROUTE_W];
        end
    end

    // Read data and error caught in the setup cycle
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            rd_hold <= 32'h0000_0000;
            err_hold <= 1'b0;
        end
        else if (setup)
        begin
            rd_hold <= i_pwrite ? 32'h0000_0000 : rd_data;
            err_hold <= ~mapped;
        end
    end

    // Trip, motor drive, stop pulse and edge history
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
        begin
            o_trip_state <= 1'b0;
            o_motor_enable <= 1'b0;
            o_stop_request <= 1'b0;
            clear_prev <= 1'b0;
        end
        else
        begin
            o_trip_state <= next_trip;
            o_motor_enable <= next_motor;
            o_stop_request <= stop_evt;
            clear_prev <= clear_level;
        end
    end

    // Bus answer and physical outputs
    assign o_pready = access;
    assign o_pslverr = access & err_hold;
    assign o_prdata = rd_hold;
    assign o_term_one = out_level[0];
    assign o_term_two = out_level[1];
    assign o_relay = out_level[2];
endmodule : old_output_logic

// >>> testbench/old_output_logic_assertions.sv
// Port-level assertions for the output logic and delay block
`timescale 1ns/10ps
module old_output_logic_assertions #(
    parameter int TICK_CYCLES = 4
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_trip_event,
    input wire logic i_running,
    input wire logic i_run_command,
    input wire logic i_fault_clear_input,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_motor_enable,
    input wire logic o_trip_state,
    input wire logic o_stop_request
);
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_reset_n);

    // Pin held long enough to cross the synchroniser while idle
    sequence s_clear_held;
        i_fault_clear_input && !i_running [*4];
    endsequence
    // Pin edge seen through two flops and the edge detector
    sequence s_pin_edge;
        $past(i_fault_clear_input, 3) != $past(i_fault_clear_input, 4);
    endsequence

    a_ready_access: assert property (o_pready == (i_psel && i_penable))
        else $error("ready outside access");
    a_err_access: assert property (o_pslverr |-> i_psel && i_penable)
        else $error("error outside access");
    a_trip_set: assert property (i_trip_event |=> o_trip_state)
        else $error("trip not set");
    a_trip_clear: assert property ($fell(o_trip_state) |-> s_pin_edge)
        else $error("trip cleared without pin edge");
    a_stop_edge: assert property ($rose(o_stop_request) |-> s_pin_edge)
        else $error("stop without pin edge");
    a_stop_running: assert property (o_stop_request |-> $past(i_running))
        else $error("stop while idle");
    a_stop_pulse: assert property (o_stop_request |=> !o_stop_request)
        else $error("stop longer than one cycle");
    a_motor_cause: assert property (o_motor_enable |-> $past(i_run_command) && !$past(o_trip_state))
        else $error("motor on without run or with trip");
    a_motor_clear: assert property (s_clear_held |-> !o_motor_enable)
        else $error("motor on during clear");
endmodule : old_output_logic_assertions

bind old_output_logic old_output_logic_assertions #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_psel(i_psel),
    .i_penable(i_penable),
    .i_trip_event(i_trip_event),
    .i_running(i_running),
    .i_run_command(i_run_command),
    .i_fault_clear_input(i_fault_clear_input),
    .o_pready(o_pready),
    .o_pslverr(o_pslverr),
    .o_motor_enable(o_motor_enable),
    .o_trip_state(o_trip_state),
    .o_stop_request(o_stop_request)
);

// >>> testbench/old_ext_ctrl.sv
// External controller model that counts stop requests from the block
`timescale 1ns/10ps
module old_ext_ctrl (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_stop_request,
    output int o_stop_count
);
    // One count per cycle of the stop pulse, so a long pulse shows up
    always_ff @(posedge i_clk or negedge i_reset_n)
    begin
        if (!i_reset_n)
            o_stop_count <= 0;
        else if (i_stop_request === 1'h1)
            o_stop_count <= o_stop_count + 1;
    end
endmodule : old_ext_ctrl

// >>> testbench/tb.sv
// Self-checking testbench for the output logic and delay block
`timescale 1ns/10ps
`include "old_params.svh"
module tb;
    import old_pkg::*;
    logic i_clk = 1'h0, i_reset_n = 1'h0, psel = 1'h0, pen = 1'h0, pwr = 1'h0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, er, t1, t2, ry, motor, trip, stop;
    logic [8:0] func = 9'h000;
    logic trip_ev = 1'h0, running = 1'h0, run_cmd = 1'h0, pin = 1'h0;
    wire logic [2:0] outs = {ry, t2, t1};
    int err_total = 0, checks_done = 0, cyc = 0, t0 = 0, n, stops, s0;

    old_output_logic #(.TICK_CYCLES(4)) uut (
        .i_clk(i_clk), .i_reset_n(i_reset_n), .i_psel(psel), .i_penable(pen),
        .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
        .o_pready(pready), .o_pslverr(pslverr), .i_status_func(func),
        .i_trip_event(trip_ev), .i_running(running), .i_run_command(run_cmd),
        .i_fault_clear_input(pin), .o_term_one(t1), .o_term_two(t2), .o_relay(ry),
        .o_motor_enable(motor), .o_trip_state(trip), .o_stop_request(stop));
    old_ext_ctrl u_ext (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_stop_request(stop),
        .o_stop_count(stops));

    initial
    begin
        forever #2 i_clk = ~i_clk;
    end

    // Hang guard, generous for the longest hold test
    always @(posedge i_clk)
    begin
        cyc <= cyc + 1;
        if (cyc == 30000)
        begin
            err_total++;
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : finish_test

    task automatic chk(input logic [31:0] act, input logic [31:0] exp, input string m);
        checks_done++;
        if (act !== exp)
        begin
            err_total++;
            $display("mismatch at %0t: %s got %h exp %h", $time, m, act, exp);
        end
    endtask : chk

    task automatic chk_win(input int v, input int lo, input int hi, input string m);
        checks_done++;
        if (v < lo || v > hi)
        begin
            err_total++;
            $display("mismatch at %0t: %s took %0d", $time, m, v);
        end
    endtask : chk_win

    // Master holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge i_clk);
        psel <= 1'h1;
        pen <= 1'h0;
        pwr <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge i_clk);
        pen <= 1'h1;
        do
            @(posedge i_clk);
        while (pready !== 1'h1);
        rd = prdata;
        er = pslverr;
        psel <= 1'h0;
        pen <= 1'h0;
    endtask : apb

    task automatic drive(input logic [8:0] f, input logic p);
        @(posedge i_clk);
        func <= f;
        pin <= p;
        t0 = cyc;
    endtask : drive

    // Edges since the last drive until an output reaches a level
    task automatic wait_out(input int idx, input logic lvl, input int lim);
        while (outs[idx] !== lvl && cyc - t0 < lim)
            @(posedge i_clk);
        n = cyc - t0;
    endtask : wait_out

    task automatic t_reset_vals();
        apb(1'h0, `OLD_OFS_COMB_CFG, 32'h0);
        chk(rd, 32'h00000010, "comb cfg");
        apb(1'h0, `OLD_OFS_ROUTE_CFG, 32'h0);
        chk(rd, 32'h00000910, "route cfg");
        for (int i = 0; i < 3; i++)
        begin
            apb(1'h0, `OLD_OFS_TERM_ONE_DLY + 8'(4 * i), 32'h0);
            chk(rd, 32'h0, "delay reset");
        end
        apb(1'h0, 8'h18, 32'h0);
        chk({31'h0, er}, 32'h1, "unmapped err");
        chk(rd, 32'h0, "unmapped data");
    endtask : t_reset_vals

    task automatic t_combiner();
        logic a, b, e;
        apb(1'h1, `OLD_OFS_ROUTE_CFG, 32'h00000999);
        // Operator code 3 gives a constant low result
        for (int op = 0; op < 4; op++)
            for (int ab = 0; ab < 4; ab++)
            begin
                a = ab[1];
                b = ab[0];
                e = (op == 0) ? (a & b) : (op == 1) ? (a | b) : (op == 2) ? (a ^ b) : 1'b0;
                apb(1'h1, `OLD_OFS_COMB_CFG, 32'h85 | (op << 8));
                drive({b, 2'h0, a, 5'h00}, 1'h0);
                repeat (4) @(posedge i_clk);
                chk(outs, {3{e}}, "combined");
            end
    endtask : t_combiner

    task automatic t_delay();
        apb(1'h1, `OLD_OFS_RELAY_DLY, 32'h03FF03FF);
        apb(1'h0, `OLD_OFS_RELAY_DLY, 32'h0);
        chk(rd, 32'h03E803E8, "delay limit");
        apb(1'h1, `OLD_OFS_RELAY_DLY, 32'h0);
        apb(1'h1, `OLD_OFS_TERM_ONE_DLY, 32'h00000002);
        apb(1'h1, `OLD_OFS_TERM_TWO_DLY, 32'h00030000);
        apb(1'h1, `OLD_OFS_COMB_CFG, 32'h185);
        drive(9'h020, 1'h0);
        wait_out(2, 1'h1, 99);
        chk_win(n, 1, 2, "relay on");
        wait_out(0, 1'h1, 99);
        chk_win(n, 9, 10, "term one on");
        drive(9'h000, 1'h0);
        wait_out(1, 1'h0, 99);
        chk_win(n, 13, 14, "term two off");
        chk(outs, 3'h0, "all off");
        // Short pulse must not survive the on delay
        drive(9'h020, 1'h0);
        repeat (4) @(posedge i_clk);
        drive(9'h000, 1'h0);
        wait_out(0, 1'h1, 40);
        chk_win(n, 40, 40, "cancelled on");
    endtask : t_delay

    task automatic t_hold();
        apb(1'h1, `OLD_OFS_TERM_ONE_DLY, 32'h00010000);
        run_cmd <= 1'h1;
        drive(9'h020, 1'h0);
        repeat (12) @(posedge i_clk);
        chk(motor, 1'h1, "motor before");
        apb(1'h0, `OLD_OFS_STATUS, 32'h0);
        chk(rd, 32'h00002037, "status word");
        drive(9'h020, 1'h1);
        wait_out(2, 1'h0, 99);
        chk_win(n, 2, 4, "relay forced off");
        chk(motor, 1'h0, "motor forced off");
        wait_out(0, 1'h0, 99);
        chk_win(n, 42, 45, "term one hold");
        drive(9'h020, 1'h0);
        repeat (12) @(posedge i_clk);
    endtask : t_hold

    task automatic clear_case(input logic [1:0] rs, input logic rn, input logic tr,
        input logic tf, input int st);
        apb(1'h1, `OLD_OFS_COMB_CFG, 32'h185 | (rs << 12));
        running <= rn;
        trip_ev <= 1'h1;
        @(posedge i_clk);
        trip_ev <= 1'h0;
        s0 = stops;
        drive(9'h020, 1'h1);
        repeat (8) @(posedge i_clk);
        chk(trip, tr, "trip after rise");
        drive(9'h020, 1'h0);
        repeat (8) @(posedge i_clk);
        chk(trip, tf, "trip after fall");
        chk(stops - s0, st, "stop count");
        repeat (50) @(posedge i_clk);
    endtask : clear_case

    task automatic t_clear();
        clear_case(2'h0, 1'h1, 1'h0, 1'h0, 1);
        clear_case(2'h1, 1'h1, 1'h1, 1'h0, 1);
        clear_case(2'h2, 1'h1, 1'h1, 1'h1, 0);
        clear_case(2'h2, 1'h0, 1'h0, 1'h0, 0);
    endtask : t_clear

    initial
    begin
        repeat (2) @(posedge i_clk);
        i_reset_n <= 1'h1;
        t_reset_vals();
        t_combiner();
        t_delay();
        t_hold();
        t_clear();
        finish_test();
    end
endmodule : tb
